// ---- src/secq_pkg.sv ----
// Constants, register map and carrier types of the secure queue registers
// How it works
// - Effective queue base aligned to larger of queue bytes or 32 bytes.
// - Base field holds address bits 51..5; other address bits are zero.
// - Written base bits above the physical address width are not stored.
// - Size exponent capped at implemented maximum internally; readback is raw.
// - Fixed queue config makes both bases read-only with preset reset value.
// - Base bit 62 gives read hint (commands) or write hint (events).
// - Failing command stores reason code and raises command queue fault in the same cycle.
// - Read index stays on failing command; resume after acknowledge if enabled.
// - Toggling command queue enable never clears or acknowledges the fault.
// - Index in low bits, wrap flag just above, at most 19 index bits.
// - Consumer bits above wrap read zero; advance wraps and toggles flag.
// - Advanced read index is published within finite time.
// - Size change keeps stored bits; smaller size sees truncated value.
// - Consumer write while disabled may load the reason code field.
// - Producer bits above wrap may be stored but have no effect.
// - Free space unless indices match with differing wrap flags.
// - Producer write starts command examination if enabled and fault-free.
// - Events written only when event queue enabled and not full.
// - Full-queue discard toggles overflow flag if it equals acknowledge flag.
package secq_pkg;

    localparam logic [11:0] OFF_CMD_BASE_LO = 12'h000;
    localparam logic [11:0] OFF_CMD_BASE_HI = 12'h004;
    localparam logic [11:0] OFF_CMD_CONS = 12'h008;
    localparam logic [11:0] OFF_CMD_PROD = 12'h00c;
    localparam logic [11:0] OFF_EVT_BASE_LO = 12'h010;
    localparam logic [11:0] OFF_EVT_BASE_HI = 12'h014;
    localparam logic [11:0] OFF_EVT_CONS = 12'h018;
    localparam logic [11:0] OFF_EVT_PROD = 12'h01c;
    localparam logic [11:0] OFF_CTRL = 12'h020;
    localparam logic [11:0] OFF_FAULT = 12'h024;
    localparam logic [11:0] OFF_FAULT_ACK = 12'h028;

    localparam int CTRL_CMD_EN_BIT = 0;
    localparam int CTRL_EVT_EN_BIT = 1;
    localparam int FAULT_CMD_BIT = 0;
    localparam int HI_HINT_BIT = 30;
    localparam int CONS_ERR_LSB = 24;
    localparam int OVF_BIT = 31;
    localparam int IDX_W = 20;
    localparam int ENTRY_BYTES_LOG2 = 4;
    localparam int MIN_ALIGN_LOG2 = 5;

    localparam logic [19:0] IDX_RST = 20'h00000;
    localparam logic [6:0] ERR_RST = 7'h00;
    localparam logic [4:0] SIZE_RST = 5'h00;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } secq_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } secq_apb_rsp_t;

    typedef struct packed {
        logic [46:0] cmdAddr;
        logic [4:0] cmdSize;
        logic cmdHint;
        logic [46:0] evtAddr;
        logic [4:0] evtSize;
        logic evtHint;
        logic [19:0] cmdRd;
        logic [6:0] cmdErr;
        logic [19:0] cmdWr;
        logic [19:0] evtRd;
        logic ovfAck;
        logic [19:0] evtWr;
        logic ovf;
        logic cmdEn;
        logic evtEn;
        logic faultSt;
        logic faultAck;
        logic kick;
        logic [31:0] prdata;
        logic pslverr;
    } secq_state_t;

endpackage

// ---- src/secq_regs.sv ----
// Secure command and event queue pointer and base registers, APB slave
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module secq_regs #(
    parameter bit FIXED_QUEUE_CONFIG = 1'b0,
    parameter logic [4:0] MAX_COMMAND_QUEUE_EXP = 5'd19,
    parameter logic [4:0] MAX_EVENT_QUEUE_EXP = 5'd19,
    parameter int OUTPUT_PHYS_WIDTH = 48,
    parameter logic [63:0] PRESET_CMD_BASE = 64'h0,
    parameter logic [63:0] PRESET_EVT_BASE = 64'h0
) (
    input wire logic clk,
    input wire logic rst,
    input wire secq_pkg::secq_apb_req_t apbReq,
    output secq_pkg::secq_apb_rsp_t apbRsp,
    input wire logic cmdConsume,
    input wire logic cmdFail,
    input wire logic [6:0] cmdFailCode,
    output logic cmdWork,
    output logic [19:0] cmdReadIdx,
    output logic [51:0] cmdBaseEff,
    output logic readAllocHint,
    output logic cmdFaultActive,
    input wire logic evtPush,
    output logic evtAccept,
    output logic evtDiscard,
    output logic [19:0] evtWriteIdx,
    output logic [51:0] evtBaseEff,
    output logic writeAllocHint,
    output logic eventOverflow
);
    import secq_pkg::*;

    localparam logic [51:0] PHYS_MASK =
        52'((53'h1 << OUTPUT_PHYS_WIDTH) - 53'h1);

    secq_state_t s_r;
    secq_state_t s_nxt;

    logic apbWr;
    logic apbSetup;
    logic [4:0] max_command_queue_exp;
    logic [4:0] evtQs;
    logic [19:0] cmdMask;
    logic [19:0] evtMask;
    logic cmdEmpty;
    logic evtFull;
    logic setKick;

    // Bits [qs:0]: index plus wrap flag
    function automatic logic [19:0] fieldMask(input logic [4:0] qs);
        return 20'((21'h1 << (qs + 5'h1)) - 21'h1);
    endfunction

    function automatic logic [4:0] capExp(input logic [4:0] sz,
                                          input logic [4:0] mx);
        return (sz > mx) ? mx : sz;
    endfunction

    // Incrementing index and wrap together wraps the index, toggles the flag
    function automatic logic [19:0] incIdx(input logic [19:0] idx,
                                           input logic [19:0] m);
        return (idx & ~m) | ((idx + 20'h1) & m);
    endfunction

    function automatic logic [51:0] effBase(input logic [46:0] addr,
                                            input logic [4:0] qs);
        logic [5:0] sh;
        sh = {1'b0, qs} + 6'(ENTRY_BYTES_LOG2);
        if (sh < 6'(MIN_ALIGN_LOG2)) begin
            sh = 6'(MIN_ALIGN_LOG2);
        end
        return {addr, 5'h00} & ~((52'h1 << sh) - 52'h1);
    endfunction

    assign apbWr = apbReq.psel && apbReq.penable && apbReq.pwrite;
    assign apbSetup = apbReq.psel && !apbReq.penable;

    assign max_command_queue_exp = capExp(s_r.cmdSize, MAX_COMMAND_QUEUE_EXP);
    assign evtQs = capExp(s_r.evtSize, MAX_EVENT_QUEUE_EXP);
    assign cmdMask = fieldMask(max_command_queue_exp);
    assign evtMask = fieldMask(evtQs);
    assign cmdEmpty = ((s_r.cmdRd ^ s_r.cmdWr) & cmdMask) == 20'h0;
    assign evtFull = ((s_r.evtRd ^ s_r.evtWr) & evtMask)
                     == (20'h1 << evtQs);
    assign cmdFaultActive = s_r.faultSt != s_r.faultAck;
    assign cmdWork = s_r.cmdEn && !cmdFaultActive && s_r.kick
                     && !cmdEmpty;
    assign evtAccept = evtPush && s_r.evtEn && !evtFull;
    assign evtDiscard = evtPush && s_r.evtEn && evtFull;
    assign cmdReadIdx = s_r.cmdRd & cmdMask;
    assign evtWriteIdx = s_r.evtWr & evtMask;
    assign cmdBaseEff = effBase(s_r.cmdAddr, max_command_queue_exp);
    assign evtBaseEff = effBase(s_r.evtAddr, evtQs);
    assign readAllocHint = s_r.cmdHint;
    assign writeAllocHint = s_r.evtHint;
    assign eventOverflow = s_r.ovf;
    assign apbRsp.pready = 1'b1;
    assign apbRsp.pslverr = s_r.pslverr;
    assign apbRsp.prdata = s_r.prdata;

    always_comb begin
        s_nxt = s_r;
        setKick = 1'b0;
        if (apbWr) begin
            case (apbReq.paddr)
                OFF_CMD_BASE_LO: begin
                    if (!FIXED_QUEUE_CONFIG && !s_r.cmdEn) begin
                        s_nxt.cmdAddr[26:0] = apbReq.pwdata[31:5]
                                              & PHYS_MASK[31:5];
                        s_nxt.cmdSize = apbReq.pwdata[4:0];
                    end
                end
                OFF_CMD_BASE_HI: begin
                    if (!FIXED_QUEUE_CONFIG && !s_r.cmdEn) begin
                        s_nxt.cmdAddr[46:27] = apbReq.pwdata[19:0]
                                               & PHYS_MASK[51:32];
                        s_nxt.cmdHint = apbReq.pwdata[HI_HINT_BIT];
                    end
                end
                OFF_CMD_CONS: begin
                    if (!s_r.cmdEn) begin
                        s_nxt.cmdRd = apbReq.pwdata[19:0];
                        s_nxt.cmdErr = apbReq.pwdata[30:24];
                    end
                end
                OFF_CMD_PROD: begin
                    s_nxt.cmdWr = apbReq.pwdata[19:0];
                    setKick = s_r.cmdEn && !cmdFaultActive;
                end
                OFF_EVT_BASE_LO: begin
                    if (!FIXED_QUEUE_CONFIG && !s_r.evtEn) begin
                        s_nxt.evtAddr[26:0] = apbReq.pwdata[31:5]
                                              & PHYS_MASK[31:5];
                        s_nxt.evtSize = apbReq.pwdata[4:0];
                    end
                end
                OFF_EVT_BASE_HI: begin
                    if (!FIXED_QUEUE_CONFIG && !s_r.evtEn) begin
                        s_nxt.evtAddr[46:27] = apbReq.pwdata[19:0]
                                               & PHYS_MASK[51:32];
                        s_nxt.evtHint = apbReq.pwdata[HI_HINT_BIT];
                    end
                end
                OFF_EVT_CONS: begin
                    s_nxt.evtRd = apbReq.pwdata[19:0];
                    s_nxt.ovfAck = apbReq.pwdata[OVF_BIT];
                end
                OFF_EVT_PROD: begin
                    if (!s_r.evtEn) begin
                        s_nxt.evtWr = apbReq.pwdata[19:0];
                    end
                end
                OFF_CTRL: begin
                    // Fault state is untouched here
                    s_nxt.cmdEn = apbReq.pwdata[CTRL_CMD_EN_BIT];
                    s_nxt.evtEn = apbReq.pwdata[CTRL_EVT_EN_BIT];
                end
                OFF_FAULT_ACK: begin
                    s_nxt.faultAck = apbReq.pwdata[FAULT_CMD_BIT];
                    // Resume after acknowledge only if enabled now
                    setKick = s_r.cmdEn;
                end
                default: begin
                end
            endcase
        end

        // Command engine: consume advances, failure holds the read index
        if (cmdWork && cmdFail) begin
            s_nxt.cmdErr = cmdFailCode;
            s_nxt.faultSt = !s_r.faultSt;
        end else if (cmdWork && cmdConsume) begin
            s_nxt.cmdRd = incIdx(s_r.cmdRd, cmdMask);
        end
        s_nxt.kick = setKick || (s_r.kick && !cmdEmpty);

        if (evtAccept) begin
            s_nxt.evtWr = incIdx(s_r.evtWr, evtMask);
        end else if (evtDiscard && s_r.ovf == s_r.ovfAck) begin
            s_nxt.ovf = !s_r.ovf;
        end

        // Read data is captured in setup so it is valid for the access phase
        if (apbSetup) begin
            s_nxt.pslverr = 1'b0;
            s_nxt.prdata = 32'h0;
            case (apbReq.paddr)
                OFF_CMD_BASE_LO: begin
                    s_nxt.prdata = {s_r.cmdAddr[26:0], s_r.cmdSize};
                end
                OFF_CMD_BASE_HI: begin
                    s_nxt.prdata = {1'b0, s_r.cmdHint, 10'h000,
                                    s_r.cmdAddr[46:27]};
                end
                OFF_CMD_CONS: begin
                    s_nxt.prdata = {1'b0, s_r.cmdErr, 4'h0,
                                    s_r.cmdRd & cmdMask};
                end
                OFF_CMD_PROD: begin
                    s_nxt.prdata = {12'h000, s_r.cmdWr};
                end
                OFF_EVT_BASE_LO: begin
                    s_nxt.prdata = {s_r.evtAddr[26:0], s_r.evtSize};
                end
                OFF_EVT_BASE_HI: begin
                    s_nxt.prdata = {1'b0, s_r.evtHint, 10'h000,
                                    s_r.evtAddr[46:27]};
                end
                OFF_EVT_CONS: begin
                    s_nxt.prdata = {s_r.ovfAck, 11'h000, s_r.evtRd & evtMask};
                end
                OFF_EVT_PROD: begin
                    s_nxt.prdata = {s_r.ovf, 11'h000, s_r.evtWr & evtMask};
                end
                OFF_CTRL: begin
                    s_nxt.prdata = {30'h0, s_r.evtEn, s_r.cmdEn};
                end
                OFF_FAULT: begin
                    s_nxt.prdata = {31'h0, s_r.faultSt};
                end
                OFF_FAULT_ACK: begin
                    s_nxt.prdata = {31'h0, s_r.faultAck};
                end
                default: begin
                    s_nxt.pslverr = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
            if (FIXED_QUEUE_CONFIG) begin
                s_r.cmdAddr <= PRESET_CMD_BASE[51:5];
                s_r.cmdSize <= PRESET_CMD_BASE[4:0];
                s_r.cmdHint <= PRESET_CMD_BASE[62];
                s_r.evtAddr <= PRESET_EVT_BASE[51:5];
                s_r.evtSize <= PRESET_EVT_BASE[4:0];
                s_r.evtHint <= PRESET_EVT_BASE[62];
            end
            s_r.cmdRd <= IDX_RST;
            s_r.cmdWr <= IDX_RST;
            s_r.cmdErr <= ERR_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence failTaken;
        cmdWork && cmdFail;
    endsequence

    sequence consRead;
        apbSetup && apbReq.paddr == OFF_CMD_CONS;
    endsequence

    fault_raise_a: assert property (
        failTaken |=> cmdFaultActive && s_r.cmdErr == $past(cmdFailCode))
        else $error("fault or reason code not recorded");

    rd_hold_a: assert property (
        cmdFaultActive && !(apbWr && apbReq.paddr == OFF_CMD_CONS)
        |=> s_r.cmdRd == $past(s_r.cmdRd))
        else $error("read index moved while fault active");

    enable_keep_a: assert property (
        cmdFaultActive && apbWr && apbReq.paddr == OFF_CTRL
        |=> cmdFaultActive)
        else $error("enable change cleared fault");

    work_gate_a: assert property (
        failTaken |=> !cmdWork)
        else $error("command work continued after a failure");

    evt_gate_a: assert property (
        evtPush && (!s_r.evtEn || evtFull)
        && !(apbWr && apbReq.paddr == OFF_EVT_PROD)
        |=> s_r.evtWr == $past(s_r.evtWr))
        else $error("event written while disabled or full");

    ovf_toggle_a: assert property (
        evtDiscard && s_r.ovf == s_r.ovfAck |=> s_r.ovf != $past(s_r.ovf))
        else $error("overflow flag not toggled");

    cons_raz_a: assert property (
        consRead ##1 1'b1 |-> (apbRsp.prdata[19:0] & ~cmdMask) == 20'h0)
        else $error("consumer bits above wrap not zero");

    rd_wrap_a: assert property (
        cmdWork && cmdConsume && !cmdFail
        && (s_r.cmdRd & cmdMask) == (cmdMask >> 1)
        |=> ((s_r.cmdRd ^ $past(s_r.cmdRd)) & $past(cmdMask))
            == $past(cmdMask))
        else $error("read index did not wrap with flag toggle");

    base_ro_a: assert property (
        apbWr && (FIXED_QUEUE_CONFIG || (s_r.cmdEn && s_r.evtEn))
        |=> s_r.cmdAddr == $past(s_r.cmdAddr)
        && s_r.evtAddr == $past(s_r.evtAddr))
        else $error("preset or guarded base changed by a write");

    align_a: assert property (
        cmdBaseEff[4:0] == 5'h00 && evtBaseEff[4:0] == 5'h00)
        else $error("queue base not 32-byte aligned");

    kick_set_a: assert property (
        apbWr && apbReq.paddr == OFF_CMD_PROD && s_r.cmdEn
        && !cmdFaultActive |=> s_r.kick)
        else $error("producer write did not start examination");

    kick_block_a: assert property (
        apbWr && apbReq.paddr == OFF_CMD_PROD
        && (!s_r.cmdEn || cmdFaultActive)
        |=> s_r.kick == ($past(s_r.kick) && !$past(cmdEmpty)))
        else $error("producer write started examination while blocked");

    err_keep_a: assert property (
        cmdFaultActive && !(apbWr && apbReq.paddr == OFF_CMD_CONS)
        |=> s_r.cmdErr == $past(s_r.cmdErr))
        else $error("reason code changed while fault active");

    ack_only_a: assert property (
        cmdFaultActive && !(apbWr && apbReq.paddr == OFF_FAULT_ACK)
        |=> cmdFaultActive)
        else $error("fault cleared without acknowledge");

    evt_adv_a: assert property (
        evtAccept |=> s_r.evtWr != $past(s_r.evtWr))
        else $error("accepted event did not advance write index");

    ovf_keep_a: assert property (
        evtPush && (!s_r.evtEn || s_r.ovf != s_r.ovfAck)
        |=> s_r.ovf == $past(s_r.ovf))
        else $error("overflow flag toggled without cause");

    slverr_a: assert property (
        apbSetup && apbReq.paddr > OFF_FAULT_ACK |=> apbRsp.pslverr)
        else $error("unmapped address not flagged");

endmodule

// ---- testbench/secq_host.sv ----
// Host software model: APB master issuing register accesses
`timescale 1ns/1ps
module secq_host
    import secq_pkg::*;
(
    input wire logic clk,
    output secq_pkg::secq_apb_req_t apbReq,
    input wire secq_pkg::secq_apb_rsp_t apbRsp
);
    logic [31:0] rdata;
    logic rerr;

    initial apbReq = '0;

    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        @(posedge clk);
        apbReq.psel <= 1'b1;
        apbReq.pwrite <= w;
        apbReq.paddr <= a;
        apbReq.pwdata <= d;
        @(posedge clk);
        apbReq.penable <= 1'b1;
        @(posedge clk);
        while (apbRsp.pready !== 1'b1) begin
            @(posedge clk);
        end
        rdata = apbRsp.prdata;
        rerr = apbRsp.pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
        // Released lines must not keep the last value
        apbReq.paddr <= ~a;
        apbReq.pwdata <= ~d;
    endtask
endmodule

// ---- testbench/tb.sv ----
// Self-checking bench of the secure queue registers
`timescale 1ns/1ps
module tb;
    import secq_pkg::*;
    localparam logic [4:0] MX = 5'd6;
    logic clk, rst, cmdConsume, cmdFail, evtPush;
    logic [6:0] cmdFailCode;
    secq_apb_req_t apbReq;
    secq_apb_rsp_t apbRsp;
    logic cmdWork, readAllocHint, cmdFaultActive, evtAccept, evtDiscard;
    logic writeAllocHint, eventOverflow;
    logic [19:0] cmdReadIdx, evtWriteIdx;
    logic [51:0] cmdBaseEff, evtBaseEff;
    int n_errors = 0;
    int compares = 0;
    logic [31:0] seed = 32'hf91302d5;
    logic [19:0] rdp, wrp, evwr, evrd;
    logic ovf, ack, evtEn;

    secq_regs #(.MAX_COMMAND_QUEUE_EXP(MX), .MAX_EVENT_QUEUE_EXP(MX)) dut (
        .clk(clk), .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp),
        .cmdConsume(cmdConsume), .cmdFail(cmdFail),
        .cmdFailCode(cmdFailCode), .cmdWork(cmdWork),
        .cmdReadIdx(cmdReadIdx), .cmdBaseEff(cmdBaseEff),
        .readAllocHint(readAllocHint), .cmdFaultActive(cmdFaultActive),
        .evtPush(evtPush), .evtAccept(evtAccept), .evtDiscard(evtDiscard),
        .evtWriteIdx(evtWriteIdx), .evtBaseEff(evtBaseEff),
        .writeAllocHint(writeAllocHint), .eventOverflow(eventOverflow));
    secq_host host (.clk(clk), .apbReq(apbReq), .apbRsp(apbRsp));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [51:0] effBase(logic [31:0] lo, logic [31:0] hi);
        logic [51:0] a;
        int s;
        s = (lo[4:0] > MX) ? MX : lo[4:0];
        s = (s + 4 > 5) ? s + 4 : 5;
        a = {hi[19:0], lo[31:5], 5'h00} & ((52'h1 << 48) - 52'h1);
        return a & ~((52'h1 << s) - 52'h1);
    endfunction

    // Wrap flag sits just above the index, so a plain add wraps and toggles
    function automatic logic [19:0] adv(logic [19:0] v, int qs);
        return (v + 20'h1) & ((20'h1 << (qs + 1)) - 20'h1);
    endfunction

    task automatic chk(string what, logic [51:0] exp, logic [51:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(logic [11:0] a, logic [31:0] d);
        host.xfer(1'b1, a, d);
        @(negedge clk);
    endtask

    task automatic rd(logic [11:0] a, logic [31:0] exp, string what);
        host.xfer(1'b0, a, 32'h0);
        chk(what, exp, host.rdata);
    endtask

    task automatic pulse(input bit fail);
        @(posedge clk);
        if (fail)
            cmdFail <= 1'b1;
        else
            cmdConsume <= 1'b1;
        @(posedge clk);
        cmdFail <= 1'b0;
        cmdConsume <= 1'b0;
        @(negedge clk);
    endtask

    task automatic push();
        logic full;
        full = evwr[0] == evrd[0] && evwr[1] != evrd[1];
        @(posedge clk);
        evtPush <= 1'b1;
        @(negedge clk);
        chk("evtAccept", evtEn && !full, evtAccept);
        chk("evtDiscard", evtEn && full, evtDiscard);
        @(posedge clk);
        evtPush <= 1'b0;
        if (evtEn && !full)
            evwr = adv(evwr, 1);
        else if (evtEn && ovf == ack)
            ovf = ~ovf;
        @(negedge clk);
        chk("evtWriteIdx", evwr, evtWriteIdx);
        chk("eventOverflow", ovf, eventOverflow);
    endtask

    task automatic print_verdict();
        if (n_errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        print_verdict();
    end

    initial begin
        logic [31:0] lo, hi;
        logic [11:0] bo;
        logic [6:0] code;
        int i, j, k;
        rst = 1'b1;
        cmdConsume = 1'b0;
        cmdFail = 1'b0;
        evtPush = 1'b0;
        cmdFailCode = 7'h00;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(OFF_CMD_CONS, 32'h0, "consRst");
        rd(OFF_CTRL, 32'h0, "ctrlRst");
        rd(OFF_FAULT, 32'h0, "faultRst");
        host.xfer(1'b0, 12'h02c, 32'h0);
        chk("slverr", 1'b1, host.rerr);
        chk("unmapped", 32'h0, host.rdata);
        for (i = 0; i < 24; i++) begin
            lo = (rnd() & 32'hffffffe0) | i;
            hi = rnd() & 32'h400fffff;
            bo = i[0] ? OFF_EVT_BASE_LO : OFF_CMD_BASE_LO;
            wr(bo, lo);
            wr(bo + 12'h004, hi);
            rd(bo, lo, "baseLo");
            host.xfer(1'b0, bo + 12'h004, 32'h0);
            chk("baseHi", hi & 32'h4000ffff, host.rdata & 32'h4000ffff);
            chk("baseEff", effBase(lo, hi),
                i[0] ? evtBaseEff : cmdBaseEff);
            chk("hint", hi[30],
                i[0] ? writeAllocHint : readAllocHint);
        end
        wr(OFF_CMD_BASE_LO, 32'h00001002);
        wr(OFF_CMD_BASE_HI, 32'h0);
        wr(OFF_CMD_CONS, 32'h7f0000ff);
        rd(OFF_CMD_CONS, 32'h7f000007, "consMask");
        wr(OFF_CMD_BASE_LO, 32'h00001000);
        rd(OFF_CMD_CONS, 32'h7f000001, "consShrink");
        wr(OFF_CMD_BASE_LO, 32'h00001002);
        wr(OFF_CMD_CONS, 32'h0);
        wr(OFF_CMD_PROD, 32'h000f0000);
        rd(OFF_CMD_PROD, 32'h000f0000, "prodStored");
        wr(OFF_CTRL, 32'h1);
        chk("idleWork", 1'b0, cmdWork);
        rdp = 20'h0;
        wrp = 20'h0;
        for (i = 0; i < 6; i++) begin
            k = (i == 2) ? 4 : rnd() % 4 + 1;
            for (j = 0; j < k; j++)
                wrp = adv(wrp, 2);
            wr(OFF_CMD_PROD, wrp);
            chk("work", 1'b1, cmdWork);
            for (j = 0; j < 8 && cmdWork === 1'b1; j++) begin
                repeat (rnd() % 3) @(posedge clk);
                pulse(1'b0);
                rdp = adv(rdp, 2);
                chk("rdIdx", rdp, cmdReadIdx);
            end
            chk("drained", wrp, cmdReadIdx);
        end
        code = 7'(rnd() % 127 + 1);
        wrp = adv(adv(wrp, 2), 2);
        wr(OFF_CMD_PROD, wrp);
        @(posedge clk);
        cmdFailCode <= code;
        pulse(1'b1);
        chk("fault", 1'b1, cmdFaultActive);
        chk("rdHeld", rdp, cmdReadIdx);
        rd(OFF_CMD_CONS, {1'b0, code, 4'h0, rdp}, "errCode");
        wr(OFF_CTRL, 32'h0);
        wr(OFF_CTRL, 32'h1);
        chk("faultKept", 1'b1, cmdFaultActive);
        wr(OFF_CMD_PROD, wrp);
        chk("stopped", 1'b0, cmdWork);
        rd(OFF_FAULT, 32'h1, "faultReg");
        wr(OFF_FAULT_ACK, 32'h1);
        chk("acked", 1'b0, cmdFaultActive);
        chk("resumed", 1'b1, cmdWork);
        pulse(1'b0);
        pulse(1'b0);
        chk("resumeIdx", wrp, cmdReadIdx);
        wr(OFF_EVT_BASE_LO, 32'h00002001);
        wr(OFF_EVT_BASE_HI, 32'h0);
        wr(OFF_EVT_CONS, 32'h0);
        wr(OFF_EVT_PROD, 32'h0);
        {evwr, evrd, ovf, ack, evtEn} = '0;
        push();
        evtEn = 1'b1;
        wr(OFF_CTRL, 32'h3);
        for (i = 0; i < 7; i++) begin
            if (i == 4) begin
                wr(OFF_EVT_CONS, 32'h80000002);
                evrd = 20'h2;
                ack = 1'b1;
            end
            push();
        end
        rd(OFF_EVT_PROD, {ovf, 11'h0, evwr}, "evtProd");
        print_verdict();
    end
endmodule
